// *** common/nsov_consts.vh ***
// Function
// RULE_01: decide start from negative sequence RMS only
// RULE_02: start when voltage exceeds percent threshold
// RULE_03: count elapsed milliseconds against delay setting
// RULE_04: trip once delay reached while started
// RULE_05: internal start and trip status outputs
// RULE_06: start-only flag suppresses general trip
// RULE_07: block input forces start and trip off
// RULE_08: general outputs combine status, flag, block
// RULE_09: operation parameter disables whole function
// RULE_10: drop below threshold or block clears all
`ifndef NSOV_CONSTS_VH
`define NSOV_CONSTS_VH
// register byte offsets
`define NSOV_OFS_CTRL 8'h00
`define NSOV_OFS_STVOL 8'h04
`define NSOV_OFS_DELAY 8'h08
`define NSOV_OFS_STAT 8'h0C
`define NSOV_OFS_VNEG 8'h10
// control fields
`define NSOV_CTRL_EN 0
`define NSOV_CTRL_STONLY 1
// status fields
`define NSOV_ST_START 0
`define NSOV_ST_TRIP 1
`define NSOV_ST_GST 2
`define NSOV_ST_GTR 3
// reset values
`define NSOV_RST_CTRL 2'h0
`define NSOV_RST_STVOL 6'h1E
`define NSOV_RST_DELAY 16'h0064
// timing
`define NSOV_CLK_HZ 100000000
`define NSOV_TICK_MS 1
// axi responses
`define NSOV_RESP_OKAY 2'h0
`define NSOV_RESP_SLVERR 2'h2
`endif

// *** rtl/nsov_top.v ***
`timescale 1ns/1ps
`include "nsov_consts.vh"
module nsov_top #(
	// clock cycles per millisecond of delay
	parameter TICK_CYCLES = (`NSOV_CLK_HZ / 1000) * `NSOV_TICK_MS,
	// width of the voltage word
	parameter VW = 16
) (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// axi4-lite write address
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// axi4-lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// axi4-lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read address
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// axi4-lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// negative sequence voltage, percent of nominal, same clock
	input wire [VW-1:0] neg_seq_voltage,
	// external block, from a pin
	input wire block_input,
	// status outputs
	output reg start_status_r,
	output reg trip_status_r,
	output reg general_start_out,
	output reg general_trip_out
);
	// register state
	reg [1:0] ctrl_r;
	reg [5:0] stvol_r;
	reg [15:0] delay_r;
	// delay timer: cycles within a millisecond, then elapsed milliseconds
	reg [31:0] tick_cnt_r;
	reg [15:0] ms_cnt_r;
	// block synchroniser stages and filtered level
	reg blk_s1_r;
	reg blk_s2_r;
	reg blk_s3_r;
	reg blk_r;
	// write address and data held until both have arrived
	reg aw_hold_r;
	reg w_hold_r;
	reg [7:0] aw_addr_r;
	reg [31:0] w_data_r;
	reg [3:0] w_strb_r;
	// decoded control bits
	wire en = ctrl_r[`NSOV_CTRL_EN];
	wire stonly = ctrl_r[`NSOV_CTRL_STONLY];
	// merge byte lanes into a word
	function [31:0] nsov_merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] strb;
		integer i;
		begin
			nsov_merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i])
					nsov_merge[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
	endfunction
	// pickup compare on negative sequence rms only
	wire above = (neg_seq_voltage > {{(VW-6){1'b0}}, stvol_r}); // RULE_01 RULE_02
	wire active = en & ~blk_r & above; // RULE_09 RULE_07 RULE_10
	// end of one millisecond of clock cycles
	wire tick = (tick_cnt_r == TICK_CYCLES - 1);
	// a write completes once address and data are present and no response is pending
	wire do_wr = (aw_hold_r | s_axi_awvalid) & (w_hold_r | s_axi_wvalid) & ~s_axi_bvalid;
	// payload from the held copy or straight from the bus
	wire [7:0] wa = aw_hold_r ? aw_addr_r : s_axi_awaddr;
	wire [31:0] wd = w_hold_r ? w_data_r : s_axi_wdata;
	wire [3:0] ws = w_hold_r ? w_strb_r : s_axi_wstrb;
	// register images after byte-lane merge
	wire [31:0] ctrl_m = nsov_merge({30'h0, ctrl_r}, wd, ws);
	wire [31:0] stv_m = nsov_merge({26'h0, stvol_r}, wd, ws);
	wire [31:0] dly_m = nsov_merge({16'h0, delay_r}, wd, ws);
	// block input synchroniser, change taken when stages two and three agree
	// the first stage is read only by the second, never by logic
	always @(posedge aclk) begin
		if (!aresetn) begin
			blk_s1_r <= 1'b0;
			blk_s2_r <= 1'b0;
			blk_s3_r <= 1'b0;
			blk_r <= 1'b0;
		end else begin
			blk_s1_r <= block_input;
			blk_s2_r <= blk_s1_r;
			blk_s3_r <= blk_s2_r;
			if (blk_s2_r == blk_s3_r)
				blk_r <= blk_s3_r;
		end
	end
	// the counter saturates at the delay so a long fault cannot wrap it
	// and a change of the delay setting while started takes effect at once
	// delay timer and internal statuses
	always @(posedge aclk) begin
		if (!aresetn || !active) begin
			tick_cnt_r <= 32'h0; // RULE_10
			ms_cnt_r <= 16'h0;
			start_status_r <= 1'b0;
			trip_status_r <= 1'b0;
		end else begin
			start_status_r <= 1'b1; // RULE_02 RULE_05
			// free-running millisecond prescaler while started
			tick_cnt_r <= tick ? 32'h0 : tick_cnt_r + 32'h1;
			if (tick && ms_cnt_r < delay_r)
				ms_cnt_r <= ms_cnt_r + 16'h1; // RULE_03
			// trip raised the edge after the count reaches the delay
			if (ms_cnt_r >= delay_r)
				trip_status_r <= 1'b1; // RULE_04 RULE_05
		end
	end
	// gated by the same active term so a block drops them with the statuses
	// general outputs
	always @(posedge aclk) begin
		if (!aresetn) begin
			general_start_out <= 1'b0;
			general_trip_out <= 1'b0;
		end else begin
			general_start_out <= active & start_status_r; // RULE_08 RULE_07
			general_trip_out <= active & trip_status_r & ~stonly; // RULE_06 RULE_08
		end
	end
	// axi write channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `NSOV_RESP_OKAY;
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			aw_addr_r <= 8'h0;
			w_data_r <= 32'h0;
			w_strb_r <= 4'h0;
			ctrl_r <= `NSOV_RST_CTRL;
			stvol_r <= `NSOV_RST_STVOL;
			delay_r <= `NSOV_RST_DELAY;
		end else if (do_wr) begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= `NSOV_RESP_OKAY;
			// read-only and unmapped offsets leave the registers alone
			case (wa)
				`NSOV_OFS_CTRL: ctrl_r <= ctrl_m[1:0]; // RULE_09 RULE_06
				`NSOV_OFS_STVOL: stvol_r <= stv_m[5:0];
				`NSOV_OFS_DELAY: delay_r <= dly_m[15:0];
				`NSOV_OFS_STAT, `NSOV_OFS_VNEG: ;
				default: s_axi_bresp <= `NSOV_RESP_SLVERR;
			endcase
		end else begin
			// take address and data apart when they arrive on separate edges
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			// response taken: open both channels for the next write
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end
	// axi read channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `NSOV_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `NSOV_RESP_OKAY;
			// data captured at the address edge, stands until rready
			case (s_axi_araddr)
				`NSOV_OFS_CTRL: s_axi_rdata <= {30'h0, ctrl_r};
				`NSOV_OFS_STVOL: s_axi_rdata <= {26'h0, stvol_r};
				`NSOV_OFS_DELAY: s_axi_rdata <= {16'h0, delay_r};
				`NSOV_OFS_STAT: s_axi_rdata <= {28'h0, general_trip_out, general_start_out,
					trip_status_r, start_status_r};
				`NSOV_OFS_VNEG: s_axi_rdata <= {{(32-VW){1'b0}}, neg_seq_voltage};
				default: begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= `NSOV_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			// response taken: accept the next address
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule // nsov_top

// *** sim/nsov_sva.sv ***
`timescale 1ns/1ps
module nsov_sva #(parameter VW = 16) (
	// clock, voltage, block and status
	input wire aclk,
	input wire aresetn,
	input wire [VW-1:0] neg_seq_voltage,
	input wire block_input,
	input wire start_status_r,
	input wire trip_status_r,
	input wire general_start_out,
	input wire general_trip_out
);
default clocking @(posedge aclk); endclocking
default disable iff (!aresetn);
// long-held causes
sequence s_blk; block_input[*6]; endsequence
sequence s_low; (neg_seq_voltage == 0)[*4]; endsequence
// status relations
property p_blk; s_blk |-> !start_status_r && !general_start_out; endproperty
a_blk: assert property (p_blk) else $error("block ignored");
property p_low; s_low |-> !start_status_r && !trip_status_r; endproperty
a_low: assert property (p_low) else $error("start at zero");
property p_tr; trip_status_r |-> start_status_r; endproperty
a_tr: assert property (p_tr) else $error("trip alone");
property p_dly; $rose(trip_status_r) |-> $past(start_status_r, 8); endproperty
a_dly: assert property (p_dly) else $error("trip early");
property p_st; $rose(start_status_r) |-> !trip_status_r; endproperty
a_st: assert property (p_st) else $error("trip at start");
property p_clr; $fell(start_status_r) |-> !trip_status_r; endproperty
a_clr: assert property (p_clr) else $error("trip kept");
property p_gs; general_start_out |-> $past(start_status_r); endproperty
a_gs: assert property (p_gs) else $error("gen start");
property p_gt; general_trip_out |-> $past(trip_status_r); endproperty
a_gt: assert property (p_gt) else $error("gen trip");
endmodule // nsov_sva
bind nsov_top nsov_sva #(.VW(VW)) chk_u (.*);

// *** sim/nsov_vsrc.sv ***
`timescale 1ns/1ps
module nsov_vsrc (
	// clock
	input wire aclk,
	// requested values
	input wire [15:0] level,
	input wire blk_req,
	// towards the block
	output reg [15:0] neg_seq_voltage = 16'h0000,
	output reg block_input = 1'b0
);
// upstream result and user block logic
always @(posedge aclk) begin
	neg_seq_voltage <= level;
	block_input <= blk_req;
end
endmodule // nsov_vsrc

// *** sim/neg_seq_overvoltage_definite_time_test.sv ***
`timescale 1ns/1ps
module neg_seq_overvoltage_definite_time_test;
localparam T = 10;
logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
logic s_axi_rready = 0, blk_req = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
logic block_input, start_status_r, trip_status_r, general_start_out, general_trip_out;
logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, d;
logic [3:0] s_axi_wstrb = 4'hF;
logic [1:0] s_axi_bresp, s_axi_rresp, r;
logic [15:0] level = 16'h0000, neg_seq_voltage;
int bad_count = 0, check_count = 0, cyc = 0, seed = 75, thr, k, i;
// clock, partner, block
initial forever #5 aclk = ~aclk;
nsov_vsrc src_u (.*);
nsov_top #(.TICK_CYCLES(T)) dut_u (.*);
task chk(input logic [31:0] g, e);
	check_count++;
	if (g !== e) begin
		bad_count++;
		$display("BAD t=%0t got %h exp %h", $time, g, e);
	end
endtask
task wr(input logic [7:0] a, input logic [31:0] v);
	s_axi_awaddr <= a;
	s_axi_wdata <= v;
	s_axi_awvalid <= 1;
	s_axi_wvalid <= 1;
	do begin
		@(posedge aclk);
		if (s_axi_awready) s_axi_awvalid <= 0;
		if (s_axi_wready) s_axi_wvalid <= 0;
	end while (!s_axi_bvalid);
	s_axi_bready <= 1;
	@(posedge aclk);
	r = s_axi_bresp;
	s_axi_bready <= 0;
endtask
task rd(input logic [7:0] a);
	s_axi_araddr <= a;
	s_axi_arvalid <= 1;
	do begin
		@(posedge aclk);
		if (s_axi_arready) s_axi_arvalid <= 0;
	end while (!s_axi_rvalid);
	s_axi_rready <= 1;
	@(posedge aclk);
	d = s_axi_rdata;
	r = s_axi_rresp;
	s_axi_rready <= 0;
endtask
// bounded wait for trip, then let outputs settle
task wtr;
	k = 0;
	while (trip_status_r !== 1'b1 && k < 2000) begin
		@(posedge aclk);
		k++;
	end
	repeat (3) @(posedge aclk);
endtask
task test_done;
	$display("checks %0d bad %0d", check_count, bad_count);
	if (bad_count == 0 && check_count > 0)
		$display("Regression OK");
	else
		$display("Regression broken");
	$finish;
endtask
// hang guard
always @(posedge aclk) begin
	cyc <= cyc + 1;
	if (cyc == 5000) begin
		bad_count++;
		test_done;
	end
end
initial begin
	repeat (6) @(posedge aclk);
	aresetn <= 1;
	for (i = 1; i < 3; i++) begin
		rd(8'(i * 4));
		chk(d, i == 1 ? 32'h1E : 32'h64);
	end
	thr = 2 + ($random(seed) & 31);
	wr(8'h04, thr);
	wr(8'h08, 32'h32);
	level <= 16'(thr + 5);
	repeat (20) @(posedge aclk);
	chk(start_status_r, 0);
	level <= 16'(thr);
	wr(8'h00, 32'h1);
	chk(r, 0);
	repeat (20) @(posedge aclk);
	chk(start_status_r, 0);
	level <= 16'(thr + 1 + ($random(seed) & 7));
	wtr;
	chk(k >= 49 * T && k <= 51 * T + 8, 1);
	rd(8'h0C);
	chk(d, 32'hF);
	blk_req <= 1;
	repeat (10) @(posedge aclk);
	chk({start_status_r, trip_status_r, general_start_out, general_trip_out}, 0);
	blk_req <= 0;
	repeat (20) @(posedge aclk);
	chk({start_status_r, trip_status_r}, 2);
	wr(8'h00, 32'h3);
	wtr;
	chk({general_start_out, general_trip_out}, 2);
	level <= 16'(thr - ($random(seed) & 1));
	repeat (10) @(posedge aclk);
	chk({start_status_r, trip_status_r, general_start_out}, 0);
	wr(8'h14, 32'h1);
	chk(r, 2);
	rd(8'h14);
	chk(r, 2);
	chk(d, 0);
	test_done;
end
endmodule // neg_seq_overvoltage_definite_time_test
